/* File: hdl/eee_pkg.sv */
// Constants shared by the low power idle control block.
package eee_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [8:0] OFS_RECOVERY  = 9'h0f2;
    localparam logic [8:0] OFS_NEXT_PAGE = 9'h0f3;
    localparam logic [8:0] OFS_EQ_WAIT   = 9'h0f4;
    localparam logic [8:0] OFS_BUF_THR   = 9'h0f6;
    localparam logic [8:0] OFS_CTRL_STAT = 9'h0f8;
    // ****************************************
    // Reset values and fields
    // ****************************************
    localparam logic [7:0]  RST_RECOVERY  = 8'h27;
    localparam logic [7:0]  RST_NEXT_PAGE = 8'h03;
    localparam logic [7:0]  NP_RW_MASK    = 8'hc3;
    localparam logic [15:0] RST_EQ_WAIT   = 16'h03e8;
    localparam logic [7:0]  RST_BUF_THR   = 8'h40;
    localparam logic        RST_EEE_EN    = 1'b1;
    localparam int          NP_P1_BIT     = 0;
    localparam int          NP_P2_BIT     = 1;
    localparam int          CS_EN_BIT     = 0;
    localparam int          CS_HOLD_BIT   = 1;
    localparam int          CS_TERM_BIT   = 2;
    localparam int          CS_REQ_LSB    = 4;
    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_PS   = 10000;
    localparam int RECOV_UNIT_PS   = 640000;
    localparam int WAIT_UNIT_US    = 1300;
    localparam int RECOV_UNIT_CYC  = RECOV_UNIT_PS / CLK_PERIOD_PS;
    localparam int WAIT_UNIT_CYC   = (WAIT_UNIT_US * 1000000) / CLK_PERIOD_PS;
    localparam int NUM_PORTS       = 3;
endpackage : eee_pkg

/* File: hdl/eee_tick.sv */
// Prescaler that emits one pulse per DIV cycles while run is held.
`timescale 1ns/100ps
module eee_tick #(
    parameter int DIV = 64
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Control
    input  wire logic run,
    output logic      tick
);
    localparam int CW = $clog2(DIV + 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          tick_q;
    logic          tick_d;

    always_comb begin
        cnt_d  = '0;
        tick_d = 1'b0;
        if (run) begin
            if (cnt_q == CW'(DIV - 1)) begin
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + CW'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule : eee_tick

/* File: hdl/eee_lpi_ctrl.sv */
// Low power idle control: recovery hold, next-page enables, empty-queue LPI requests, buffer-load termination.
`timescale 1ns/100ps
module eee_lpi_ctrl #(
    parameter int WAIT_UNIT_CYC = eee_pkg::WAIT_UNIT_CYC,
    parameter int LOAD_W        = 8
) (
    // Clock and reset
    input  wire logic                                  REF_CLK,
    input  wire logic                                  RST_N,
    // Register port
    input  wire logic [8:0]                            REG_ADDR,
    input  wire logic [15:0]                           REG_WDATA,
    input  wire logic                                  REG_WR,
    input  wire logic                                  REG_RD,
    output logic      [15:0]                           REG_RDATA,
    // Port status
    input  wire logic [eee_pkg::NUM_PORTS-1:0]         TRANSMIT_QUEUE_EMPTY,
    input  wire logic [eee_pkg::NUM_PORTS*LOAD_W-1:0]  PORT_BUF_LOAD,
    input  wire logic                                  P2_LPI_EXIT,
    // Control outputs
    output logic      [eee_pkg::NUM_PORTS-1:0]         LPI_REQ,
    output logic                                       LPI_TERMINATE,
    output logic                                       P2_TX_HOLD,
    output logic                                       P1_NP_EN,
    output logic                                       P2_NP_EN
);
    localparam int NP = eee_pkg::NUM_PORTS;

    typedef enum logic {REC_IDLE, REC_HOLD} eee_rec_t;

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0]  recov_q,  recov_d;
    logic [7:0]  np_q,     np_d;
    logic [15:0] wait_q,   wait_d;
    logic [7:0]  thr_q,    thr_d;
    logic        en_q,     en_d;
    logic [15:0] rdata_q,  rdata_d;
    logic [15:0] rd_val;

    always_comb begin
        recov_d = recov_q;
        np_d    = np_q;
        wait_d  = wait_q;
        thr_d   = thr_q;
        en_d    = en_q;
        if (REG_WR) begin
            unique case (REG_ADDR)
                eee_pkg::OFS_RECOVERY:  recov_d = REG_WDATA[7:0];
                eee_pkg::OFS_NEXT_PAGE: np_d    = REG_WDATA[7:0] & eee_pkg::NP_RW_MASK;
                eee_pkg::OFS_EQ_WAIT:   wait_d  = REG_WDATA;
                eee_pkg::OFS_BUF_THR:   thr_d   = REG_WDATA[7:0];
                eee_pkg::OFS_CTRL_STAT: en_d    = REG_WDATA[eee_pkg::CS_EN_BIT];
                default: ;
            endcase
        end
        rd_val = 16'h0000;
        unique case (REG_ADDR)
            eee_pkg::OFS_RECOVERY:  rd_val = {8'h00, recov_q};
            eee_pkg::OFS_NEXT_PAGE: rd_val = {8'h00, np_q};
            eee_pkg::OFS_EQ_WAIT:   rd_val = wait_q;
            eee_pkg::OFS_BUF_THR:   rd_val = {8'h00, thr_q};
            eee_pkg::OFS_CTRL_STAT: begin
                rd_val[eee_pkg::CS_EN_BIT]                      = en_q;
                rd_val[eee_pkg::CS_HOLD_BIT]                    = P2_TX_HOLD;
                rd_val[eee_pkg::CS_TERM_BIT]                    = LPI_TERMINATE;
                rd_val[eee_pkg::CS_REQ_LSB +: eee_pkg::NUM_PORTS] = LPI_REQ;
            end
            default: ;
        endcase
        rdata_d = REG_RD ? rd_val : 16'h0000;
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            recov_q <= eee_pkg::RST_RECOVERY;
            np_q    <= eee_pkg::RST_NEXT_PAGE;
            wait_q  <= eee_pkg::RST_EQ_WAIT;
            thr_q   <= eee_pkg::RST_BUF_THR;
            en_q    <= eee_pkg::RST_EEE_EN;
            rdata_q <= 16'h0000;
        end else begin
            recov_q <= recov_d;
            np_q    <= np_d;
            wait_q  <= wait_d;
            thr_q   <= thr_d;
            en_q    <= en_d;
            rdata_q <= rdata_d;
        end
    end

    // ****************************************
    // Port 2 recovery hold
    // ****************************************
    eee_rec_t   rec_q, rec_d;
    logic [7:0] rcnt_q, rcnt_d;
    logic       rec_tick;
    logic       hold_d;

    eee_tick #(.DIV(eee_pkg::RECOV_UNIT_CYC)) u_rec_tick (
        .clk   (REF_CLK),
        .rst_n (RST_N),
        .run   ((rec_q == REC_HOLD) && !P2_LPI_EXIT),
        .tick  (rec_tick)
    );

    always_comb begin
        rec_d  = rec_q;
        rcnt_d = rcnt_q;
        if (P2_LPI_EXIT) begin
            rcnt_d = 8'h00;
            rec_d  = (recov_q == 8'h00) ? REC_IDLE : REC_HOLD;
        end else begin
            unique case (rec_q)
                REC_IDLE: rcnt_d = 8'h00;
                REC_HOLD: begin
                    if (rec_tick) begin
                        rcnt_d = rcnt_q + 8'h01;
                    end
                    if (rcnt_d >= recov_q) begin
                        rec_d = REC_IDLE;
                    end
                end
            endcase
        end
        hold_d = (rec_d == REC_HOLD);
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            rec_q      <= REC_IDLE;
            rcnt_q     <= 8'h00;
            P2_TX_HOLD <= 1'b0;
        end else begin
            rec_q      <= rec_d;
            rcnt_q     <= rcnt_d;
            P2_TX_HOLD <= hold_d;
        end
    end

    // ****************************************
    // Empty-queue wait and buffer load
    // ****************************************
    logic [16:0]   wcnt_q [NP];
    logic [16:0]   wcnt_d [NP];
    logic [NP-1:0] w_tick;
    logic [NP-1:0] run_w;
    logic [NP-1:0] req_d;
    logic          term_d;

    genvar g;
    generate
        for (g = 0; g < NP; g++) begin : g_port
            assign run_w[g] = en_q && TRANSMIT_QUEUE_EMPTY[g];
            eee_tick #(.DIV(WAIT_UNIT_CYC)) u_wait_tick (
                .clk   (REF_CLK),
                .rst_n (RST_N),
                .run   (run_w[g]),
                .tick  (w_tick[g])
            );
        end
    endgenerate

    always_comb begin
        term_d = 1'b0;
        for (int i = 0; i < NP; i++) begin
            if (PORT_BUF_LOAD[i*LOAD_W +: LOAD_W] > LOAD_W'(thr_q)) begin
                term_d = 1'b1;
            end
        end
        for (int i = 0; i < NP; i++) begin
            if (!run_w[i]) begin
                wcnt_d[i] = 17'h00000;
            end else if (w_tick[i] && !wcnt_q[i][16]) begin
                wcnt_d[i] = wcnt_q[i] + 17'h00001;
            end else begin
                wcnt_d[i] = wcnt_q[i];
            end
            req_d[i] = run_w[i] && (wcnt_q[i] > {1'b0, wait_q}) && !term_d;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            for (int i = 0; i < NP; i++) begin
                wcnt_q[i] <= 17'h00000;
            end
            LPI_REQ       <= '0;
            LPI_TERMINATE <= 1'b0;
            P1_NP_EN      <= eee_pkg::RST_NEXT_PAGE[eee_pkg::NP_P1_BIT];
            P2_NP_EN      <= eee_pkg::RST_NEXT_PAGE[eee_pkg::NP_P2_BIT];
        end else begin
            wcnt_q        <= wcnt_d;
            LPI_REQ       <= req_d;
            LPI_TERMINATE <= term_d;
            P1_NP_EN      <= np_d[eee_pkg::NP_P1_BIT];
            P2_NP_EN      <= np_d[eee_pkg::NP_P2_BIT];
        end
    end

    assign REG_RDATA = rdata_q;

    // ****************************************
    // Assertions
    // ****************************************
    logic [15:0] hold_len_q;
    always_ff @(posedge REF_CLK) begin
        if (!RST_N || P2_LPI_EXIT || !P2_TX_HOLD) begin
            hold_len_q <= 16'h0000;
        end else begin
            hold_len_q <= hold_len_q + 16'h0001;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    property p_rec_start;
        P2_LPI_EXIT && (recov_q != 8'h00) |=> P2_TX_HOLD;
    endproperty
    a_rec_start: assert property (p_rec_start) else $error("hold not raised after LPI exit");
    property p_rec_len;
        $fell(P2_TX_HOLD) && !$past(P2_LPI_EXIT) |->
            ($past(hold_len_q) + 16'h0002) >= 16'($past(recov_q) * eee_pkg::RECOV_UNIT_CYC);
    endproperty
    a_rec_len: assert property (p_rec_len) else $error("hold released too early");
    property p_np2;
        REG_WR && (REG_ADDR == eee_pkg::OFS_NEXT_PAGE) |=> P2_NP_EN == $past(REG_WDATA[1]);
    endproperty
    a_np2: assert property (p_np2) else $error("port 2 next-page enable not updated");
    property p_np1;
        REG_WR && (REG_ADDR == eee_pkg::OFS_NEXT_PAGE) |=> P1_NP_EN == $past(REG_WDATA[0]);
    endproperty
    a_np1: assert property (p_np1) else $error("port 1 next-page enable not updated");
    property p_req_cause;
        $rose(LPI_REQ[0]) |-> $past(TRANSMIT_QUEUE_EMPTY[0]) && ($past(wcnt_q[0]) > {1'b0, $past(wait_q)});
    endproperty
    a_req_cause: assert property (p_req_cause) else $error("LPI request without expired wait");
    property p_eee_off;
        !en_q ##1 !en_q |-> LPI_REQ == '0;
    endproperty
    a_eee_off: assert property (p_eee_off) else $error("LPI request while EEE disabled");
    property p_same_wait;
        LPI_REQ[2] |-> $past(wcnt_q[2]) > {1'b0, $past(wait_q)};
    endproperty
    a_same_wait: assert property (p_same_wait) else $error("port 3 ignores shared wait");
    property p_term;
        LPI_TERMINATE |-> LPI_REQ == '0;
    endproperty
    a_term: assert property (p_term) else $error("LPI request during termination");
    property p_term_set;
        (PORT_BUF_LOAD[LOAD_W-1:0] > LOAD_W'(thr_q)) |=> LPI_TERMINATE;
    endproperty
    a_term_set: assert property (p_term_set) else $error("termination missed");
    property p_restart;
        !TRANSMIT_QUEUE_EMPTY[1] |=> wcnt_q[1] == 17'h00000;
    endproperty
    a_restart: assert property (p_restart) else $error("wait timer not restarted");

    c_hold: cover property ($fell(P2_TX_HOLD));
    c_req:  cover property ($rose(LPI_REQ[0]));
    c_term: cover property ($rose(LPI_TERMINATE));
endmodule : eee_lpi_ctrl

/* File: tb/eee_link_partner.sv */
// Behavioural remote link partner that wakes port 2 out of low power idle.
`timescale 1ns/100ps
module eee_link_partner (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Bench command
    input  wire logic wake,
    // Link event toward the device
    output logic      lpi_exit
);
    logic wake_q;
    logic wake_d;
    logic exit_q;
    logic exit_d;

    // A wake request becomes exactly one exit pulse, as the far end leaves idle once.
    always_comb begin
        wake_d = wake;
        exit_d = wake & ~wake_q;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wake_q <= 1'b0;
            exit_q <= 1'b0;
        end else begin
            wake_q <= wake_d;
            exit_q <= exit_d;
        end
    end

    assign lpi_exit = exit_q;
endmodule : eee_link_partner

/* File: tb/eee_low_power_idle_control_tb_top.sv */
// Self-checking bench for the low power idle control block.
`timescale 1ns/100ps
module eee_low_power_idle_control_tb_top;
    logic        ref_clk   = 1'b0;
    logic        rst_n     = 1'b0;
    logic [8:0]  reg_addr  = 9'h000;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr    = 1'b0;
    logic        reg_rd    = 1'b0;
    logic [2:0]  q_empty   = 3'h0;
    logic [23:0] buf_load  = 24'h000000;
    logic        wake      = 1'b0;
    logic [15:0] reg_rdata;
    logic        lpi_exit;
    logic [2:0]  lpi_req;
    logic        lpi_term;
    logic        tx_hold;
    logic        p1_np;
    logic        p2_np;
    int          err_count = 0;
    int          n_tests   = 0;

    always #5 ref_clk = ~ref_clk;

    eee_lpi_ctrl #(.WAIT_UNIT_CYC(4)) DUT (
        .REF_CLK(ref_clk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .TRANSMIT_QUEUE_EMPTY(q_empty), .PORT_BUF_LOAD(buf_load), .P2_LPI_EXIT(lpi_exit),
        .LPI_REQ(lpi_req), .LPI_TERMINATE(lpi_term), .P2_TX_HOLD(tx_hold),
        .P1_NP_EN(p1_np), .P2_NP_EN(p2_np)
    );

    eee_link_partner u_partner (.clk(ref_clk), .rst_n(rst_n), .wake(wake), .lpi_exit(lpi_exit));

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [8:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), exp, reg_rdata);
    endtask : rd

    task automatic pulse_wake();
        @(posedge ref_clk);
        wake <= 1'b1;
        @(posedge ref_clk);
        wake <= 1'b0;
        cyc(1);
    endtask : pulse_wake

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    initial begin
        repeat (3000) @(posedge ref_clk);
        err_count++;
        $display("[ERR] watchdog expected done seen timeout");
        wrap_up();
    end

    initial begin
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        cyc(1);
        chk("np_en", 16'h0003, {14'h0, p2_np, p1_np});
        chk("outs", 16'h0000, {11'h0, lpi_req, lpi_term, tx_hold});
        rd(eee_pkg::OFS_RECOVERY, 16'h0027);
        rd(eee_pkg::OFS_NEXT_PAGE, 16'h0003);
        rd(eee_pkg::OFS_EQ_WAIT, 16'h03e8);
        rd(eee_pkg::OFS_BUF_THR, 16'h0040);
        rd(eee_pkg::OFS_CTRL_STAT, 16'h0001);
        rd(9'h0fa, 16'h0000);
        wr(eee_pkg::OFS_NEXT_PAGE, 16'h00ff);
        rd(eee_pkg::OFS_NEXT_PAGE, 16'h00c3);
        wr(eee_pkg::OFS_NEXT_PAGE, 16'h0001);
        cyc(2);
        chk("np_en", 16'h0001, {14'h0, p2_np, p1_np});
        wr(eee_pkg::OFS_NEXT_PAGE, 16'h0002);
        cyc(2);
        chk("np_en", 16'h0002, {14'h0, p2_np, p1_np});
        wr(eee_pkg::OFS_BUF_THR, 16'hffff);
        rd(eee_pkg::OFS_BUF_THR, 16'h00ff);
        wr(eee_pkg::OFS_BUF_THR, 16'h0040);
        wr(eee_pkg::OFS_RECOVERY, 16'h0002);
        pulse_wake();
        chk("hold", 16'h0001, {15'h0, tx_hold});
        rd(eee_pkg::OFS_CTRL_STAT, 16'h0003);
        cyc(124);
        chk("hold", 16'h0001, {15'h0, tx_hold});
        cyc(10);
        chk("hold", 16'h0000, {15'h0, tx_hold});
        wr(eee_pkg::OFS_RECOVERY, 16'h0000);
        pulse_wake();
        cyc(1);
        chk("hold", 16'h0000, {15'h0, tx_hold});
        wr(eee_pkg::OFS_EQ_WAIT, 16'h0002);
        @(posedge ref_clk);
        q_empty <= 3'b101;
        cyc(9);
        chk("req", 16'h0000, {13'h0, lpi_req});
        cyc(11);
        chk("req", 16'h0005, {13'h0, lpi_req});
        @(posedge ref_clk);
        q_empty <= 3'b111;
        cyc(6);
        chk("req", 16'h0005, {13'h0, lpi_req});
        cyc(14);
        chk("req", 16'h0007, {13'h0, lpi_req});
        @(posedge ref_clk);
        q_empty <= 3'b011;
        cyc(2);
        chk("req", 16'h0003, {13'h0, lpi_req});
        wr(eee_pkg::OFS_CTRL_STAT, 16'h0000);
        cyc(20);
        chk("req", 16'h0000, {13'h0, lpi_req});
        wr(eee_pkg::OFS_CTRL_STAT, 16'h0001);
        cyc(20);
        chk("req", 16'h0003, {13'h0, lpi_req});
        rd(eee_pkg::OFS_CTRL_STAT, 16'h0031);
        @(posedge ref_clk);
        buf_load <= 24'h404040;
        cyc(2);
        chk("term", 16'h0000, {15'h0, lpi_term});
        @(posedge ref_clk);
        buf_load <= 24'h410000;
        cyc(2);
        chk("term", 16'h0001, {15'h0, lpi_term});
        chk("req", 16'h0000, {13'h0, lpi_req});
        rd(eee_pkg::OFS_CTRL_STAT, 16'h0005);
        wr(eee_pkg::OFS_BUF_THR, 16'h0041);
        cyc(2);
        chk("term", 16'h0000, {15'h0, lpi_term});
        @(posedge ref_clk);
        buf_load <= 24'h000042;
        cyc(2);
        chk("term", 16'h0001, {15'h0, lpi_term});
        wrap_up();
    end
endmodule : eee_low_power_idle_control_tb_top
